// ---- hdl/supply_mon_pkg.sv ----
package supply_mon_pkg;

  // ************************************************************
  // Bus and register map
  // ************************************************************
  localparam int          BUS_ADDR_W    = 12;
  localparam int          BUS_DATA_W    = 32;
  // Register indices; the byte address is four times the index
  localparam logic [11:0] IDX_SUPPLY    = 12'h150;
  localparam logic [11:0] IDX_BATTERY   = 12'h151;
  localparam logic [11:0] ADDR_SUPPLY   = {IDX_SUPPLY[9:0], 2'b00};
  localparam logic [11:0] ADDR_BATTERY  = {IDX_BATTERY[9:0], 2'b00};

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int POS_ANALOG_EXT    = 7;
  localparam int POS_ANALOG_VALID  = 6;
  localparam int POS_SUPPLY_RSV_HI = 5;
  localparam int POS_SUPPLY_RSV_LO = 4;
  localparam int POS_DIGITAL_EXT   = 3;
  localparam int POS_DIGITAL_VALID = 2;
  localparam int POS_TRIM_HI       = 1;
  localparam int POS_TRIM_LO       = 0;
  localparam int POS_BAT_PENDING   = 7;
  localparam int POS_BAT_ENABLE    = 6;
  localparam int POS_BAT_ABOVE     = 5;
  localparam int POS_BAT_RANGE     = 4;
  localparam int POS_BAT_CODE_HI   = 3;
  localparam int POS_BAT_CODE_LO   = 0;

  // ************************************************************
  // Reset values and thresholds
  // ************************************************************
  localparam logic [7:0]  SUPPLY_RESET  = 8'h00;
  localparam logic [7:0]  BATTERY_RESET = 8'h00;
  localparam logic [11:0] HI_BASE_MV    = 12'd2550;
  localparam logic [11:0] HI_STEP_MV    = 12'd75;
  localparam logic [11:0] LO_BASE_MV    = 12'd1700;
  localparam logic [11:0] LO_STEP_MV    = 12'd50;

  typedef logic [11:0] millivolt_t;

  typedef struct packed {
    logic       analog_external_regulator_sel;
    logic       analog_supply_valid;
    logic [1:0] reserved_bits;
    logic       digital_external_regulator_sel;
    logic       digital_supply_valid;
    logic [1:0] digital_regulator_trim;
  } supply_ctrl_s;

  typedef struct packed {
    logic       battery_low_pending;
    logic       battery_low_irq_enable;
    logic       battery_above_threshold;
    logic       battery_range_select;
    logic [3:0] battery_threshold_code;
  } battery_ctrl_s;

endpackage : supply_mon_pkg

// ---- hdl/supply_and_battery_monitor_regs.sv ----
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - Analog valid reads one once regulator settled
// - Digital external select is storage without effect
// - Digital valid follows digital regulator settled
// - Writing one clears battery low pending
// - Enable bit gates battery interrupt request
// - Comparison bit shows supply above threshold
// - Range bit picks low or high span
// - Threshold code sets base plus code steps
// - Pending/enable act as status/mask pair
// - Analog external select forces analog valid
// - Interrupt service acknowledge clears pending flag
module supply_and_battery_monitor_regs
  import supply_mon_pkg::*;
#(
  parameter int ADDR_W = BUS_ADDR_W,
  parameter int DATA_W = BUS_DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [DATA_W-1:0] writedata,
  input  wire logic [3:0]        byteenable,
  output logic      [DATA_W-1:0] readdata,
  output logic                   waitrequest,
  input  wire logic              analog_regulator_settled,
  input  wire logic              digital_regulator_settled,
  input  wire millivolt_t        external_supply_rail_mv,
  input  wire logic              irq_service_ack,
  output logic                   analog_regulator_disable,
  output logic                   battery_range_select,
  output logic      [3:0]        battery_threshold_code,
  output logic                   irq
);

  // ************************************************************
  // Decode helpers
  // ************************************************************

  // Word match; low two address bits are ignored as for any word slave
  function automatic logic hits(input logic [ADDR_W-1:0] addr,
                                input logic [11:0]       base);
    hits = (addr[ADDR_W-1:2] == base[ADDR_W-1:2]);
  endfunction : hits

  // Comparison level in millivolts for a range and a code
  function automatic millivolt_t threshold_mv(input logic       high_range,
                                              input logic [3:0] code);
    millivolt_t step;
    millivolt_t base;
    step = high_range ? HI_STEP_MV : LO_STEP_MV;
    base = high_range ? HI_BASE_MV : LO_BASE_MV;
    threshold_mv = 12'(base + 12'(step * {8'h00, code}));
  endfunction : threshold_mv

  // ************************************************************
  // State
  // ************************************************************
  supply_ctrl_s      supply_q;
  supply_ctrl_s      next_supply;
  battery_ctrl_s     battery_q;
  battery_ctrl_s     next_battery;
  logic              next_irq;
  logic              next_waitrequest;
  logic [DATA_W-1:0] next_readdata;
  logic              write_taken;
  logic              hit_supply;
  logic              hit_battery;
  logic              falls_below;
  logic              clear_pending;
  millivolt_t        active_threshold;

  // Bus request decode shared by both register groups
  assign hit_supply  = hits(address, ADDR_SUPPLY);
  assign hit_battery = hits(address, ADDR_BATTERY);
  // Write lands only at the edge where waitrequest is seen low
  assign write_taken = write & ~waitrequest & byteenable[0];

  // ************************************************************
  // Supply register
  // ************************************************************

  // Next value of the regulator control and status bits
  always_comb begin
    next_supply = supply_q;
    if (write_taken && hit_supply) begin
      next_supply.analog_external_regulator_sel  = writedata[POS_ANALOG_EXT];
      next_supply.reserved_bits  = writedata[POS_SUPPLY_RSV_HI:POS_SUPPLY_RSV_LO];
      next_supply.digital_external_regulator_sel = writedata[POS_DIGITAL_EXT];
      next_supply.digital_regulator_trim = writedata[POS_TRIM_HI:POS_TRIM_LO];
    end
    // External analog supply means no internal settling to wait for
    next_supply.analog_supply_valid = next_supply.analog_external_regulator_sel
                                      | analog_regulator_settled;
    // Digital select is deliberately not looked at here
    next_supply.digital_supply_valid = digital_regulator_settled;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_q                 <= supply_ctrl_s'(SUPPLY_RESET);
      analog_regulator_disable <= 1'b0;
    end else begin
      supply_q                 <= next_supply;
      analog_regulator_disable <= next_supply.analog_external_regulator_sel;
    end
  end

  // ************************************************************
  // Battery monitor register
  // ************************************************************

  // Threshold follows the settings currently held, so a new code acts next cycle
  assign active_threshold = threshold_mv(battery_q.battery_range_select,
                                         battery_q.battery_threshold_code);

  // Next value of the battery monitor bits
  always_comb begin
    next_battery = battery_q;
    if (write_taken && hit_battery) begin
      next_battery.battery_low_irq_enable = writedata[POS_BAT_ENABLE];
      next_battery.battery_range_select   = writedata[POS_BAT_RANGE];
      next_battery.battery_threshold_code = writedata[POS_BAT_CODE_HI:POS_BAT_CODE_LO];
    end
    // Equal counts as below: the bit promises strictly above
    next_battery.battery_above_threshold =
      (external_supply_rail_mv > active_threshold);
    falls_below = battery_q.battery_above_threshold
                  & ~next_battery.battery_above_threshold;
    clear_pending = (write_taken && hit_battery && writedata[POS_BAT_PENDING])
                    || irq_service_ack;
    // A new fall in the clearing cycle is kept: set wins over clear
    if (falls_below) begin
      next_battery.battery_low_pending = 1'b1;
    end else if (clear_pending) begin
      next_battery.battery_low_pending = 1'b0;
    end
    next_irq = next_battery.battery_low_pending
               & next_battery.battery_low_irq_enable;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      battery_q <= battery_ctrl_s'(BATTERY_RESET);
      irq       <= 1'b0;
    end else begin
      battery_q <= next_battery;
      irq       <= next_irq;
    end
  end

  // Pins towards the analog comparator come straight from the register
  assign battery_range_select   = battery_q.battery_range_select;
  assign battery_threshold_code = battery_q.battery_threshold_code;

  // ************************************************************
  // Avalon-MM slave
  // ************************************************************

  // One wait cycle per access; keeps read data a clean register output
  always_comb begin
    next_waitrequest = ~((read | write) & waitrequest);
    next_readdata    = readdata;
    if (read && waitrequest) begin
      if (hit_supply) begin
        next_readdata = {{(DATA_W-8){1'b0}}, supply_q};
      end else if (hit_battery) begin
        next_readdata = {{(DATA_W-8){1'b0}}, battery_q};
      end else begin
        next_readdata = '0; // Unmapped reads as zero
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= '0;
    end else begin
      waitrequest <= next_waitrequest;
      readdata    <= next_readdata;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************

  property p_analog_valid_forced;
    @(posedge core_clk) disable iff (!rst_n)
      (supply_q.analog_external_regulator_sel
       && $past(supply_q.analog_external_regulator_sel))
      |-> supply_q.analog_supply_valid;
  endproperty
  a_analog_valid_forced: assert property (p_analog_valid_forced)
    else $error("analog valid low with external regulator selected");

  property p_analog_valid_follows;
    @(posedge core_clk) disable iff (!rst_n)
      (!supply_q.analog_external_regulator_sel
       && !$past(supply_q.analog_external_regulator_sel))
      |-> (supply_q.analog_supply_valid == $past(analog_regulator_settled));
  endproperty
  a_analog_valid_follows: assert property (p_analog_valid_follows)
    else $error("analog valid does not follow regulator settled");

  property p_digital_valid_follows;
    @(posedge core_clk) disable iff (!rst_n)
      ##1 (supply_q.digital_supply_valid == $past(digital_regulator_settled));
  endproperty
  a_digital_valid_follows: assert property (p_digital_valid_follows)
    else $error("digital valid does not follow regulator settled");

  property p_digital_sel_stored;
    @(posedge core_clk) disable iff (!rst_n)
      (write_taken && hit_supply)
      |=> (supply_q.digital_external_regulator_sel == $past(writedata[POS_DIGITAL_EXT]));
  endproperty
  a_digital_sel_stored: assert property (p_digital_sel_stored)
    else $error("digital external select not stored");

  property p_pending_w1c;
    @(posedge core_clk) disable iff (!rst_n)
      (write_taken && hit_battery && writedata[POS_BAT_PENDING] && !falls_below)
      |=> !battery_q.battery_low_pending;
  endproperty
  a_pending_w1c: assert property (p_pending_w1c)
    else $error("pending not cleared by write of one");

  property p_pending_service_clear;
    @(posedge core_clk) disable iff (!rst_n)
      (irq_service_ack && !falls_below) |=> !battery_q.battery_low_pending;
  endproperty
  a_pending_service_clear: assert property (p_pending_service_clear)
    else $error("pending not cleared by service acknowledge");

  property p_pending_on_fall;
    @(posedge core_clk) disable iff (!rst_n)
      (battery_q.battery_above_threshold ##1 !battery_q.battery_above_threshold)
      |-> battery_q.battery_low_pending;
  endproperty
  a_pending_on_fall: assert property (p_pending_on_fall)
    else $error("pending not set on fall below threshold");

  property p_irq_gated;
    @(posedge core_clk) disable iff (!rst_n)
      irq == (battery_q.battery_low_pending && battery_q.battery_low_irq_enable);
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt output does not match pending and enable");

  property p_compare_result;
    @(posedge core_clk) disable iff (!rst_n)
      ##1 (battery_q.battery_above_threshold
           == $past(external_supply_rail_mv > active_threshold));
  endproperty
  a_compare_result: assert property (p_compare_result)
    else $error("comparison bit wrong for threshold");

  property p_threshold_low_base;
    @(posedge core_clk) disable iff (!rst_n)
      (!battery_q.battery_range_select && battery_q.battery_threshold_code == 4'h0)
      |-> (active_threshold == 12'd1700);
  endproperty
  a_threshold_low_base: assert property (p_threshold_low_base)
    else $error("low range base threshold wrong");

  property p_threshold_high_top;
    @(posedge core_clk) disable iff (!rst_n)
      (battery_q.battery_range_select && battery_q.battery_threshold_code == 4'hf)
      |-> (active_threshold == 12'd3675);
  endproperty
  a_threshold_high_top: assert property (p_threshold_high_top)
    else $error("high range top threshold wrong");

  property p_pending_only_on_fall;
    @(posedge core_clk) disable iff (!rst_n)
      (!battery_q.battery_low_pending ##1 battery_q.battery_low_pending)
      |-> $past(falls_below);
  endproperty
  a_pending_only_on_fall: assert property (p_pending_only_on_fall)
    else $error("pending set without a fall below threshold");

  // Only a clear may drop the flag; writes of zero must leave it alone
  property p_pending_holds;
    @(posedge core_clk) disable iff (!rst_n)
      (battery_q.battery_low_pending && !clear_pending)
      |=> battery_q.battery_low_pending;
  endproperty
  a_pending_holds: assert property (p_pending_holds)
    else $error("pending lost without a clear");

  property p_threshold_low_top;
    @(posedge core_clk) disable iff (!rst_n)
      (!battery_q.battery_range_select && battery_q.battery_threshold_code == 4'hf)
      |-> (active_threshold == 12'd2450);
  endproperty
  a_threshold_low_top: assert property (p_threshold_low_top)
    else $error("low range top threshold wrong");

  property p_threshold_high_base;
    @(posedge core_clk) disable iff (!rst_n)
      (battery_q.battery_range_select && battery_q.battery_threshold_code == 4'h0)
      |-> (active_threshold == 12'd2550);
  endproperty
  a_threshold_high_base: assert property (p_threshold_high_base)
    else $error("high range base threshold wrong");

  property p_wait_idle;
    @(posedge core_clk) disable iff (!rst_n)
      !(read || write) |=> waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest low without a request");

  property p_readdata_upper_zero;
    @(posedge core_clk) disable iff (!rst_n)
      readdata[DATA_W-1:8] == '0;
  endproperty
  a_readdata_upper_zero: assert property (p_readdata_upper_zero)
    else $error("read data upper bits not zero");

  // Read data must be the register as it stood when the request was seen
  property p_read_capture;
    @(posedge core_clk) disable iff (!rst_n)
      (read && waitrequest && hit_battery)
      |=> (readdata[7:0] == $past(battery_q));
  endproperty
  a_read_capture: assert property (p_read_capture)
    else $error("battery register read data wrong");

  property p_bus_answer;
    @(posedge core_clk) disable iff (!rst_n)
      ((read || write) && waitrequest) |=> !waitrequest ##1 waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("bus answer not given one cycle after request");

endmodule : supply_and_battery_monitor_regs

`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb;
  import supply_mon_pkg::*;

  // ************************************************************
  // Stimulus signals
  // ************************************************************
  logic        core_clk        = 1'b0;
  logic        rst_n           = 1'b0;
  logic [11:0] address         = 12'h000;
  logic        read            = 1'b0;
  logic        write           = 1'b0;
  logic [31:0] writedata       = 32'h0000_0000;
  logic [3:0]  byteenable      = 4'hf;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        analog_settled  = 1'b0;
  logic        digital_settled = 1'b0;
  millivolt_t  rail_mv         = 12'h000;
  logic        svc_ack         = 1'b0;
  logic        an_disable;
  logic        range_q;
  logic [3:0]  code_q;
  logic        irq;
  int          err_count       = 0;
  int          samples_checked = 0;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  supply_and_battery_monitor_regs i_dut (
    .core_clk                  (core_clk),
    .rst_n                     (rst_n),
    .address                   (address),
    .read                      (read),
    .write                     (write),
    .writedata                 (writedata),
    .byteenable                (byteenable),
    .readdata                  (readdata),
    .waitrequest               (waitrequest),
    .analog_regulator_settled  (analog_settled),
    .digital_regulator_settled (digital_settled),
    .external_supply_rail_mv   (rail_mv),
    .irq_service_ack           (svc_ack),
    .analog_regulator_disable  (an_disable),
    .battery_range_select      (range_q),
    .battery_threshold_code    (code_q),
    .irq                       (irq)
  );

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // One Avalon access; request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d,
                     input logic [3:0] be, output logic [7:0] rd);
    @(posedge core_clk);
    address    <= a;
    writedata  <= {24'h000000, d};
    byteenable <= be;
    write      <= wr;
    read       <= ~wr;
    // Outputs read right after the edge still hold what that edge sampled
    // A missing answer is left to the watchdog
    do begin
      @(posedge core_clk);
    end while (waitrequest !== 1'b0);
    rd = readdata[7:0];
    write <= 1'b0;
    read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] rd;
    bus(1'b1, a, d, 4'hf, rd);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp, input string what);
    logic [7:0] rd;
    bus(1'b0, a, 8'h00, 4'hf, rd);
    chk(rd, exp, what);
  endtask : rd_chk

  // Status inputs are registered, so give them a few edges to land
  task automatic settle;
    repeat (3) @(posedge core_clk);
  endtask : settle

  task automatic set_rail(input millivolt_t mv);
    @(posedge core_clk);
    rail_mv <= mv;
    settle();
  endtask : set_rail

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_supply;
    rd_chk(ADDR_SUPPLY, 8'h00, "valid bits low while unsettled");
    wr(ADDR_SUPPLY, 8'h3b);
    rd_chk(ADDR_SUPPLY, 8'h3b, "digital select is plain storage");
    @(posedge core_clk);
    analog_settled <= 1'b1;
    digital_settled <= 1'b1;
    settle();
    rd_chk(ADDR_SUPPLY, 8'h7f, "both valid bits set");
    @(posedge core_clk);
    analog_settled <= 1'b0;
    settle();
    rd_chk(ADDR_SUPPLY, 8'h3f, "analog valid drops");
    wr(ADDR_SUPPLY, 8'hbb);
    settle();
    rd_chk(ADDR_SUPPLY, 8'hff, "external select forces analog valid");
    chk({7'h00, an_disable}, 8'h01, "analog regulator disabled");
    begin
      logic [7:0] rd;
      bus(1'b1, ADDR_SUPPLY, 8'h00, 4'h0, rd);
    end
    rd_chk(ADDR_SUPPLY, 8'hff, "write without byte enable ignored");
    wr(ADDR_SUPPLY, 8'h00);
    @(posedge core_clk);
    digital_settled <= 1'b0;
    settle();
    rd_chk(ADDR_SUPPLY, 8'h00, "digital valid drops");
    chk({7'h00, an_disable}, 8'h00, "analog regulator enabled again");
  endtask : t_supply

  // Every code in both ranges: equal reads below, one millivolt more above
  task automatic t_threshold;
    millivolt_t thr;
    logic [7:0] cfg;
    logic [7:0] rd;
    for (int r = 0; r < 2; r++) begin
      for (int c = 0; c < 16; c++) begin
        thr = (r == 1) ? millivolt_t'(2550 + 75 * c) : millivolt_t'(1700 + 50 * c);
        cfg = {3'b000, r[0], c[3:0]};
        wr(ADDR_BATTERY, cfg);
        set_rail(thr);
        bus(1'b0, ADDR_BATTERY, 8'h00, 4'hf, rd);
        chk({2'b00, rd[5:0]}, cfg, "at threshold reads below");
        set_rail(thr + 12'd1);
        bus(1'b0, ADDR_BATTERY, 8'h00, 4'hf, rd);
        chk({2'b00, rd[5:0]}, cfg | 8'h20, "above threshold");
        chk({3'b000, range_q, code_q}, cfg, "range and code outputs");
      end
    end
  endtask : t_threshold

  task automatic t_irq;
    wr(ADDR_BATTERY, 8'h80);
    set_rail(12'd3000);
    rd_chk(ADDR_BATTERY, 8'h20, "pending cleared, above");
    wr(ADDR_BATTERY, 8'h40);
    set_rail(12'd1000);
    rd_chk(ADDR_BATTERY, 8'hc0, "fall sets pending");
    chk({7'h00, irq}, 8'h01, "enabled pending raises irq");
    wr(ADDR_BATTERY, 8'hc0);
    rd_chk(ADDR_BATTERY, 8'h40, "write one clears pending");
    chk({7'h00, irq}, 8'h00, "irq drops after clear");
    wr(ADDR_BATTERY, 8'h00);
    set_rail(12'd3000);
    set_rail(12'd1000);
    rd_chk(ADDR_BATTERY, 8'h80, "pending sets while disabled");
    chk({7'h00, irq}, 8'h00, "masked pending gives no irq");
    wr(ADDR_BATTERY, 8'h40);
    settle();
    chk({7'h00, irq}, 8'h01, "enable exposes pending");
    @(posedge core_clk);
    svc_ack <= 1'b1;
    @(posedge core_clk);
    svc_ack <= 1'b0;
    settle();
    chk({7'h00, irq}, 8'h00, "service ack drops irq");
    rd_chk(ADDR_BATTERY, 8'h40, "service ack clears pending");
  endtask : t_irq

  task automatic t_unmapped;
    wr(12'h548, 8'hff);
    rd_chk(12'h548, 8'h00, "unmapped reads zero");
    rd_chk(ADDR_SUPPLY, 8'h00, "unmapped write harmless");
  endtask : t_unmapped

  // ************************************************************
  // Main sequence and watchdog
  // ************************************************************
  // Run order matters: each scenario leaves registers in a known state
  initial begin
    repeat (2) @(posedge core_clk);
    chk({6'h00, waitrequest, irq}, 8'h02, "outputs in reset");
    chk(readdata[7:0], 8'h00, "readdata in reset");
    rst_n <= 1'b1;
    settle();
    rd_chk(ADDR_BATTERY, 8'h00, "battery register after reset");
    t_supply();
    t_threshold();
    t_irq();
    t_unmapped();
    print_verdict();
  end

  // Whole run is well under 5000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    print_verdict();
  end

endmodule : tb

`default_nettype wire
